// ---- logic/loop_frame_acceptor_driver.sv ----
`timescale 1ns/1ps

// output frame queue; registered ready and valid so that the flags are honest
module loop_frame_fifo
#(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
)
(
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];   // frame storage
	logic [AW-1:0]    wr_ptr;        // next slot to fill
	logic [AW-1:0]    rd_ptr;        // oldest slot
	logic [AW:0]      count;         // words held
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	// occupancy after this edge
	always_comb
	begin
		next_count = count;
		if (push && !pop)
			next_count = count + (AW+1)'(1);
		else if (pop && !push)
			next_count = count - (AW+1)'(1);
	end

	// storage has no reset; only words counted valid are ever read
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointers and flags
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'h1;
			out_valid <= 1'h0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
			count     <= next_count;
			in_ready  <= next_count != (AW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end
endmodule

module loop_frame_acceptor_driver
#(
	parameter int FIFO_DEPTH = lfa_pkg::OUT_FIFO_DEPTH
)
(
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	input  wire logic              rx_bit_strobe,
	input  wire logic              rx_bit,
	input  wire logic              rx_sync,
	output logic                   tx_bit_strobe,
	output logic                   tx_bit,
	output logic                   tx_sync,
	input  wire logic              talker_active_bit,
	input  wire logic              listener_active_bit,
	input  wire logic              controller_active_bit,
	input  wire logic              system_controller,
	input  wire logic              set_local_ready_bit,
	input  wire logic              clear_interface_clear,
	input  wire logic              host_read_any,
	input  wire logic              host_read_rx_data,
	input  wire logic              out_write_valid,
	input  wire lfa_pkg::frame_type out_write_data,
	output logic                   out_write_ready,
	output lfa_pkg::frame_type     rx_frame,
	output logic [2:0]             ctrl_image,
	output logic                   frame_available_flag,
	output logic                   frame_error_flag,
	output logic                   output_available_flag,
	output logic                   interface_clear_received,
	output logic                   local_ready_flag,
	output logic                   frame_match_flag,
	output logic                   receive_transfer_abort,
	output logic                   load_receive_regs_strobe,
	output logic                   output_pointer_done,
	output logic                   acceptor_idle_status
);
	logic [4:0]                  tick_count;      // slow-rate divider
	logic                        tick;            // one state machine step
	logic [3:0]                  in_ptr;          // index of last received bit
	logic                        frame_active;    // bits still expected
	logic [10:0]                 in_buffer;       // raw incoming bits
	logic [10:0]                 next_buffer;
	logic                        buffer_has_ident_or_cmd;
	logic                        ident_cmd_event; // identify/command seen while busy
	logic                        abort_seen;      // abort held until next step
	logic                        input_register_load_gate;
	lfa_pkg::frame_type          in_reg;          // frame under decode
	logic                        early_retransmit_enable;
	lfa_pkg::acceptor_state_type acc;
	lfa_pkg::acceptor_state_type next_acc;
	lfa_pkg::driver_state_type   drv;
	lfa_pkg::frame_type          out_reg;         // last sourced frame
	lfa_pkg::frame_type          send_frame;
	logic [3:0]                  out_ptr;         // output bit pointer
	logic                        send_ok;
	logic                        served;          // driver took acceptor request
	logic                        awaiting_return; // sourced frame due back
	logic                        go_load;         // failed check heads to load
	logic                        arm_output_available;
	logic                        fifo_valid;
	lfa_pkg::frame_type          fifo_data;
	logic                        pop;
	logic                        host_write;
	logic                        bit_differs;
	logic                        check_done;
	logic                        flags_clear;

	assign tick        = tick_count == lfa_pkg::TICK_LAST;
	assign host_write  = out_write_valid && out_write_ready;
	assign flags_clear = !frame_available_flag && !frame_error_flag;
	assign check_done  = (acc == lfa_pkg::acceptor_error_check) && !input_register_load_gate
		&& (out_ptr == lfa_pkg::LAST_BIT);
	assign bit_differs = lfa_pkg::frame_bit(in_reg, out_ptr) != lfa_pkg::frame_bit(out_reg, out_ptr);
	assign pop = tick && (drv == lfa_pkg::driver_idle) && (acc == lfa_pkg::acceptor_idle)
		&& !input_register_load_gate && !frame_active && fifo_valid;

	loop_frame_fifo
	#(
		.WIDTH (11),
		.DEPTH (FIFO_DEPTH)
	)
	out_fifo
	(
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (out_write_valid),
		.in_ready  (out_write_ready),
		.in_data   (out_write_data),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_data)
	);

	// slow tick; a divider instead of a second clock keeps one domain
	// derived stepping rate
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			tick_count <= '0;
		else
			tick_count <= tick ? '0 : tick_count + 5'h01;
	end

	// buffer image after this edge's bit
	always_comb
	begin
		next_buffer = in_buffer;
		if (rx_bit_strobe && rx_sync)
			next_buffer = {rx_bit, 10'h000};
		else if (rx_bit_strobe && frame_active)
			next_buffer[lfa_pkg::LAST_BIT - (in_ptr + 4'h1)] = rx_bit;
	end

	// receiver: pointer, buffer, abort detect
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			in_ptr                 <= '0;
			frame_active           <= 1'h0;
			in_buffer              <= '0;
			buffer_has_ident_or_cmd <= 1'h0;
			receive_transfer_abort <= 1'h0;
		end
		else
		begin
			receive_transfer_abort <= 1'h0;
			in_buffer              <= next_buffer;
			if (rx_bit_strobe && rx_sync)
			begin
				receive_transfer_abort <= frame_active;
				in_ptr                 <= '0;
				frame_active           <= 1'h1;
				buffer_has_ident_or_cmd <= 1'h0;
			end
			else if (rx_bit_strobe && frame_active)
			begin
				in_ptr       <= in_ptr + 4'h1;
				frame_active <= (in_ptr + 4'h1) != lfa_pkg::LAST_BIT;
				if ((in_ptr + 4'h1) == lfa_pkg::IDENT_CMD_PTR)
					buffer_has_ident_or_cmd <= next_buffer[10:9] == 2'h3
						|| next_buffer[10:8] == lfa_pkg::CTRL_CMD;
			end
		end
	end

	// events held for the slow step; a new event beats the step's clear
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			abort_seen      <= 1'h0;
			ident_cmd_event <= 1'h0;
		end
		else
		begin
			if (receive_transfer_abort)
				abort_seen <= 1'h1;
			else if (tick)
				abort_seen <= 1'h0;
			if (buffer_has_ident_or_cmd && frame_active && !input_register_load_gate)
				ident_cmd_event <= 1'h1;
			else if (tick)
				ident_cmd_event <= 1'h0;
		end
	end

	// input register gate and early retransmit enable
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			input_register_load_gate <= 1'h0;
			in_reg                   <= lfa_pkg::FRAME_RESET;
			early_retransmit_enable  <= 1'h0;
		end
		else
		begin
			if (receive_transfer_abort || (input_register_load_gate && !frame_active))
				input_register_load_gate <= 1'h0;
			// open only into an idle acceptor and a driver that is not retransmitting
			else if (frame_active && acc == lfa_pkg::acceptor_idle
				&& drv != lfa_pkg::driver_retransmit
				&& ((rx_bit_strobe && rx_sync && in_ptr == 4'h0) || buffer_has_ident_or_cmd
					|| !input_register_load_gate))
				input_register_load_gate <= 1'h1;
			if (input_register_load_gate)
				in_reg <= next_buffer;
			if (lfa_pkg::is_ident(in_reg) || lfa_pkg::is_cmd(in_reg))
				early_retransmit_enable <= input_register_load_gate
					&& in_ptr >= lfa_pkg::EARLY_PTR_IDENT;
			else
				early_retransmit_enable <= input_register_load_gate
					&& in_ptr >= lfa_pkg::EARLY_PTR_OTHER;
		end
	end

	// acceptor decisions
	always_comb
	begin
		next_acc = acc;
		unique case (acc)
			lfa_pkg::acceptor_idle:
				if (input_register_load_gate)
					next_acc = lfa_pkg::acceptor_load_input;
			lfa_pkg::acceptor_load_input:
				if (abort_seen)
					next_acc = lfa_pkg::acceptor_idle;
				else if (talker_active_bit && listener_active_bit)
					next_acc = lfa_pkg::acceptor_analyzer_state;
				// data at sync, command and identify at early enable
				else if (!controller_active_bit && !awaiting_return
					&& (lfa_pkg::is_data(in_reg) || ((lfa_pkg::is_cmd(in_reg)
					|| lfa_pkg::is_ident(in_reg)) && early_retransmit_enable)))
					next_acc = lfa_pkg::acceptor_retransmit;
				else if (input_register_load_gate)
					next_acc = lfa_pkg::acceptor_load_input;
				else if (controller_active_bit && (lfa_pkg::is_rfc(in_reg)
					|| (!system_controller && lfa_pkg::is_cmd(in_reg)
					&& in_reg.data == lfa_pkg::IFC_DATA)))
					next_acc = lfa_pkg::acceptor_handshake_state;
				else if (awaiting_return)
					next_acc = lfa_pkg::acceptor_error_check;
				else if (!controller_active_bit && lfa_pkg::is_rfc(in_reg))
					next_acc = local_ready_flag ? lfa_pkg::acceptor_auto_reply
						: lfa_pkg::acceptor_wait_ready;
				else
					next_acc = lfa_pkg::acceptor_wait_host;
			lfa_pkg::acceptor_retransmit:
				if (served && drv == lfa_pkg::driver_idle && !input_register_load_gate)
				begin
					if (lfa_pkg::is_cmd(in_reg) || (lfa_pkg::is_data(in_reg)
						&& listener_active_bit))
					begin
						if (flags_clear)
							next_acc = lfa_pkg::acceptor_load_state;
					end
					else
						next_acc = lfa_pkg::acceptor_idle;
				end
			lfa_pkg::acceptor_analyzer_state:
				if (!input_register_load_gate)
					next_acc = lfa_pkg::acceptor_wait_host;
			lfa_pkg::acceptor_wait_host:
				// new identify/command drops the held frame
				if (ident_cmd_event)
					next_acc = lfa_pkg::acceptor_idle;
				else if (flags_clear)
					next_acc = lfa_pkg::acceptor_load_state;
			lfa_pkg::acceptor_load_state:
				if (!host_read_any)
					next_acc = lfa_pkg::acceptor_idle;
			lfa_pkg::acceptor_error_check:
				if (host_write)
					next_acc = lfa_pkg::acceptor_idle;
				else if (check_done)
				begin
					if (!frame_match_flag || bit_differs)
						next_acc = lfa_pkg::acceptor_handshake_state;
					else if (lfa_pkg::is_cmd(in_reg))
						next_acc = lfa_pkg::acceptor_auto_reply;
					else
						next_acc = lfa_pkg::acceptor_handshake_state;
				end
			lfa_pkg::acceptor_handshake_state:
				next_acc = go_load ? lfa_pkg::acceptor_wait_host : lfa_pkg::acceptor_idle;
			lfa_pkg::acceptor_auto_reply:
				if (served && drv == lfa_pkg::driver_idle)
					next_acc = lfa_pkg::acceptor_idle;
			lfa_pkg::acceptor_wait_ready:
				if (ident_cmd_event)
					next_acc = lfa_pkg::acceptor_idle;
				else if (local_ready_flag)
					next_acc = lfa_pkg::acceptor_auto_reply;
			default:
				next_acc = lfa_pkg::acceptor_idle;
		endcase
	end

	// acceptor state register and its side flags
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			acc                  <= lfa_pkg::acceptor_idle;
			go_load              <= 1'h0;
			acceptor_idle_status <= 1'h1;
		end
		else
		begin
			if (tick)
			begin
				acc                  <= next_acc;
				acceptor_idle_status <= next_acc == lfa_pkg::acceptor_idle;
				if (acc == lfa_pkg::acceptor_error_check && check_done)
					go_load <= !frame_match_flag || bit_differs;
				else if (acc == lfa_pkg::acceptor_handshake_state)
					go_load <= 1'h0;
			end
		end
	end

	// sourced frame is expected back for checking
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			awaiting_return <= 1'h0;
		// armed at launch: a short loop can echo the frame before it is fully sent
		else if (pop)
			awaiting_return <= 1'h1;
		else if (tick && acc == lfa_pkg::acceptor_load_input && next_acc != acc)
			awaiting_return <= 1'h0;
	end

	// match flag
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			frame_match_flag <= 1'h0;
		// set on entry, cleared only by a compare miss
		else if (tick && acc == lfa_pkg::acceptor_idle && next_acc != acc)
			frame_match_flag <= 1'h1;
		else if (tick && acc == lfa_pkg::acceptor_error_check && !input_register_load_gate
			&& bit_differs)
			frame_match_flag <= 1'h0;
	end

	// retransmit waits for each bit to arrive so the receiver is never overrun
	always_comb
	begin
		send_ok    = 1'h1;
		send_frame = out_reg;
		unique case (drv)
			lfa_pkg::driver_retransmit:
			begin
				send_frame = in_reg;
				send_ok    = !input_register_load_gate || out_ptr <= in_ptr;
			end
			lfa_pkg::driver_ready_reply:
				send_frame = lfa_pkg::RFC_FRAME;
			lfa_pkg::driver_source,
			lfa_pkg::driver_idle:
				send_frame = out_reg;
		endcase
	end

	// output pointer, shared by transmission and error checking
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			out_ptr             <= '0;
			output_pointer_done <= 1'h0;
		end
		else
		begin
			output_pointer_done <= 1'h0;
			if (tick && acc == lfa_pkg::acceptor_error_check && host_write)
				out_ptr <= '0;
			else if (tick && ((drv != lfa_pkg::driver_idle && send_ok)
				|| (acc == lfa_pkg::acceptor_error_check && !input_register_load_gate)))
			begin
				out_ptr             <= (out_ptr == lfa_pkg::LAST_BIT) ? '0 : out_ptr + 4'h1;
				output_pointer_done <= out_ptr == lfa_pkg::LAST_BIT;
			end
		end
	end

	// driver machine and transmit bits
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			drv           <= lfa_pkg::driver_idle;
			served        <= 1'h0;
			out_reg       <= lfa_pkg::FRAME_RESET;
			tx_bit_strobe <= 1'h0;
			tx_bit        <= 1'h0;
			tx_sync       <= 1'h0;
		end
		else
		begin
			tx_bit_strobe <= 1'h0;
			if (acc != lfa_pkg::acceptor_retransmit && acc != lfa_pkg::acceptor_auto_reply)
				served <= 1'h0;
			if (tick)
			begin
				unique case (drv)
					lfa_pkg::driver_idle:
						if (acc == lfa_pkg::acceptor_retransmit && !served)
						begin
							served <= 1'h1;
							drv    <= lfa_pkg::driver_retransmit;
						end
						else if (acc == lfa_pkg::acceptor_auto_reply && !served)
						begin
							served <= 1'h1;
							drv    <= lfa_pkg::driver_ready_reply;
						end
						else if (pop)
						begin
							out_reg <= fifo_data;
							drv     <= lfa_pkg::driver_source;
						end
					lfa_pkg::driver_retransmit,
					lfa_pkg::driver_source,
					lfa_pkg::driver_ready_reply:
						if (send_ok)
						begin
							tx_bit_strobe <= 1'h1;
							tx_bit        <= lfa_pkg::frame_bit(send_frame, out_ptr);
							tx_sync       <= out_ptr == 4'h0;
							if (out_ptr == lfa_pkg::LAST_BIT)
								drv <= lfa_pkg::driver_idle;
						end
				endcase
			end
		end
	end

	// host-facing registers and flags; every set wins over its clear
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_frame                 <= lfa_pkg::FRAME_RESET;
			ctrl_image               <= 3'h0;
			load_receive_regs_strobe <= 1'h0;
			frame_available_flag     <= 1'h0;
			frame_error_flag         <= 1'h0;
			arm_output_available     <= 1'h0;
			output_available_flag    <= 1'h0;
			interface_clear_received <= 1'h0;
			local_ready_flag         <= 1'h0;
		end
		else
		begin
			load_receive_regs_strobe <= 1'h0;
			if (host_read_rx_data)
			begin
				frame_available_flag <= 1'h0;
				frame_error_flag     <= 1'h0;
				ctrl_image           <= rx_frame.ctrl;
			end
			// no load while the host reads
			if (tick && acc == lfa_pkg::acceptor_load_state && !host_read_any)
			begin
				// copy frame, one flag by match
				load_receive_regs_strobe <= 1'h1;
				rx_frame                 <= in_reg;
				frame_available_flag     <= frame_match_flag;
				frame_error_flag         <= !frame_match_flag;
			end
			// armed while waiting, spent on the return to idle
			if (tick && acc == lfa_pkg::acceptor_wait_host
				&& next_acc != lfa_pkg::acceptor_idle)
				arm_output_available <= 1'h1;
			else if (tick && acc != lfa_pkg::acceptor_idle && next_acc == lfa_pkg::acceptor_idle)
				arm_output_available <= 1'h0;
			if (tick && acc != lfa_pkg::acceptor_idle && next_acc == lfa_pkg::acceptor_idle
				&& (arm_output_available || acc == lfa_pkg::acceptor_handshake_state
				|| acc == lfa_pkg::acceptor_wait_host))
				output_available_flag <= 1'h1;
			else if (host_write)
				output_available_flag <= 1'h0;
			if (tick && acc == lfa_pkg::acceptor_load_input && controller_active_bit
				&& !system_controller && !input_register_load_gate && lfa_pkg::is_cmd(in_reg)
				&& in_reg.data == lfa_pkg::IFC_DATA)
				interface_clear_received <= 1'h1;
			else if (clear_interface_clear)
				interface_clear_received <= 1'h0;
			if (set_local_ready_bit)
				local_ready_flag <= 1'h1;
			else if (tick && acc == lfa_pkg::acceptor_auto_reply && next_acc != acc)
				local_ready_flag <= 1'h0;
		end
	end
endmodule

// ---- include/lfa_pkg.sv ----
package lfa_pkg;

	// clock rates: the ref clock steps the state machines at the derived slow rate
	localparam int unsigned REF_CLK_HZ  = 10_000_000;
	localparam int unsigned LOOP_CLK_HZ = 2_000_000;
	localparam int unsigned SM_CLK_HZ   = 500_000;
	localparam int unsigned TICK_CYCLES = REF_CLK_HZ / SM_CLK_HZ;
	localparam logic [4:0]  TICK_LAST   = 5'(TICK_CYCLES - 1);

	// frame geometry: bit 0 (first, sync) lands in vector position 10
	localparam logic [3:0]  LAST_BIT        = 4'hA;
	localparam logic [3:0]  IDENT_CMD_PTR   = 4'h2;
	localparam logic [3:0]  EARLY_PTR_IDENT = 4'h3;
	localparam logic [3:0]  EARLY_PTR_OTHER = 4'h5;

	// control field codes and special data values
	localparam logic [2:0]  CTRL_CMD = 3'h4;
	localparam logic [2:0]  CTRL_RDY = 3'h5;
	localparam logic [7:0]  IFC_DATA = 8'h90;
	localparam logic [7:0]  RFC_DATA = 8'h00;

	// output queue depth
	localparam int          OUT_FIFO_DEPTH = 16;

	typedef struct packed
	{
		logic [2:0] ctrl;
		logic [7:0] data;
	} frame_type;

	localparam frame_type FRAME_RESET = '{ctrl: 3'h0, data: 8'h00};
	localparam frame_type RFC_FRAME   = '{ctrl: CTRL_RDY, data: RFC_DATA};

	typedef enum logic [3:0]
	{
		acceptor_idle            = 4'h0,
		acceptor_load_input      = 4'h1,
		acceptor_retransmit      = 4'h2,
		acceptor_analyzer_state  = 4'h3,
		acceptor_wait_host       = 4'h4,
		acceptor_load_state      = 4'h5,
		acceptor_error_check     = 4'h6,
		acceptor_handshake_state = 4'h7,
		acceptor_auto_reply      = 4'h8,
		acceptor_wait_ready      = 4'h9
	} acceptor_state_type;

	typedef enum logic [1:0]
	{
		driver_idle        = 2'h0,
		driver_retransmit  = 2'h1,
		driver_source      = 2'h2,
		driver_ready_reply = 2'h3
	} driver_state_type;

	// bit p of the frame in transmission order
	function automatic logic frame_bit(frame_type f, logic [3:0] p);
		logic [10:0] v;
		v = f;
		return v[LAST_BIT - p];
	endfunction

	function automatic logic is_data(frame_type f);
		return !f.ctrl[2];
	endfunction

	function automatic logic is_cmd(frame_type f);
		return f.ctrl == CTRL_CMD;
	endfunction

	function automatic logic is_ident(frame_type f);
		return f.ctrl[2:1] == 2'h3;
	endfunction

	function automatic logic is_rfc(frame_type f);
		return (f.ctrl == CTRL_RDY) && (f.data == RFC_DATA);
	endfunction

endpackage

// ---- sim/lfa_sva.sv ----
`timescale 1ns/1ps
// pin-level relations between host strobes, loads and flags
module lfa_sva
(
	input wire logic               ref_clk,
	input wire logic               nrst,
	input wire logic               host_read_any,
	input wire logic               host_read_rx_data,
	input wire logic               out_write_valid,
	input wire logic               out_write_ready,
	input wire lfa_pkg::frame_type rx_frame,
	input wire logic [2:0]         ctrl_image,
	input wire logic               frame_available_flag,
	input wire logic               frame_error_flag,
	input wire logic               output_available_flag,
	input wire logic               frame_match_flag,
	input wire logic               receive_transfer_abort,
	input wire logic               load_receive_regs_strobe,
	input wire logic               output_pointer_done,
	input wire logic               acceptor_idle_status
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	load_one_flag_a: assert property (load_receive_regs_strobe |->
		(frame_available_flag ^ frame_error_flag) && frame_available_flag == frame_match_flag)
		else $error("load set wrong flag");
	rx_hold_a: assert property (!load_receive_regs_strobe |-> $stable(rx_frame))
		else $error("receive frame moved without load");
	read_inhibit_a: assert property (host_read_any |=> !load_receive_regs_strobe)
		else $error("load during host read");
	read_clear_a: assert property (host_read_rx_data && host_read_any |=>
		!frame_available_flag && !frame_error_flag) else $error("read left a flag");
	ctrl_copy_a: assert property (host_read_rx_data && host_read_any |=>
		ctrl_image == $past(rx_frame.ctrl)) else $error("control image not copied");
	abort_idle_a: assert property (receive_transfer_abort |-> ##[1:21] acceptor_idle_status)
		else $error("abort left acceptor busy");
	done_pulse_a: assert property (output_pointer_done |=> !output_pointer_done)
		else $error("pointer done held");
	write_clear_a: assert property (out_write_valid && out_write_ready |=>
		!output_available_flag) else $error("output available kept after write");
endmodule
bind loop_frame_acceptor_driver lfa_sva chk (.*);

// ---- sim/loop_partner.sv ----
`timescale 1ns/1ps
// loop neighbours: sends frames in, collects ours, may echo them back
module loop_partner
(
	input  wire logic  ref_clk,
	input  wire logic  echo,
	input  wire logic  tx_bit_strobe,
	input  wire logic  tx_bit,
	input  wire logic  tx_sync,
	output logic       rx_bit_strobe,
	output logic       rx_bit,
	output logic       rx_sync,
	output logic [10:0] got,
	output logic       got_valid
);
	int cnt = 0; // bits of the frame being collected
	initial
	begin
		rx_bit_strobe = 0;
		rx_sync = 0;
		rx_bit = 0;
	end
	// one bit per step, msb first; line inverted between bits so no stale value
	task automatic send(input logic [10:0] f, input int n);
		for (int i = 10; i > 10 - n; i--)
		begin
			repeat (19) @(posedge ref_clk);
			#5 {rx_bit_strobe, rx_bit, rx_sync} = {1'b1, f[i], i == 10};
			@(posedge ref_clk);
			#5 {rx_bit_strobe, rx_bit, rx_sync} = {1'b0, ~rx_bit, 1'b0};
		end
	endtask
	// collect eleven bits after a sync; echo closes the loop on ourselves
	always @(posedge ref_clk)
	begin
		got_valid <= tx_bit_strobe && !tx_sync && cnt == 10;
		if (tx_bit_strobe)
		begin
			got <= {got[9:0], tx_bit};
			cnt <= tx_sync ? 1 : cnt + 1;
		end
		if (echo)
		begin
			rx_bit_strobe <= tx_bit_strobe;
			rx_sync <= tx_sync;
			rx_bit <= tx_bit_strobe ? tx_bit : ~rx_bit;
		end
	end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
// host side driven here, loop side through the partner
module tb;
	logic ref_clk = 0, nrst = 0, echo = 0, tx_bit_strobe, tx_bit, tx_sync;
	logic rx_bit_strobe, rx_bit, rx_sync, got_valid, out_write_ready, acceptor_idle_status;
	logic talker_active_bit = 0, listener_active_bit = 0, controller_active_bit = 0;
	logic system_controller = 0, set_local_ready_bit = 0, clear_interface_clear = 0;
	logic host_read_any = 0, host_read_rx_data = 0, out_write_valid = 0;
	logic frame_available_flag, frame_error_flag, output_available_flag, frame_match_flag;
	logic interface_clear_received, local_ready_flag, receive_transfer_abort;
	logic load_receive_regs_strobe, output_pointer_done;
	logic [2:0] ctrl_image;
	logic [10:0] got, f;
	logic [11:0] exp_tx[$], exp_rx[$]; // notes of expected frames
	lfa_pkg::frame_type out_write_data = '0, rx_frame;
	int fails = 0, comparisons = 0, seed = 94042, n, aborts = 0;
	loop_frame_acceptor_driver dut (.*);
	loop_partner far (.*);
	always #50 ref_clk = ~ref_clk;
	task check(input logic [11:0] a, input logic [11:0] e);
		comparisons++;
		if (a !== e)
		begin
			fails++;
			$display("ERROR %0t got %h want %h", $time, a, e);
		end
	endtask
	task end_of_test();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// bounded wait for a loaded frame, then one host read of it
	task take();
		for (n = 0; frame_available_flag !== 1'b1 && frame_error_flag !== 1'b1; n++)
		begin
			@(posedge ref_clk);
			if (n > 3000)
			begin
				fails++;
				end_of_test();
			end
		end
		@(posedge ref_clk);
		#5 {host_read_any, host_read_rx_data} = 2'b11;
		@(posedge ref_clk);
		#5 {host_read_any, host_read_rx_data} = 2'b00;
	endtask
	// each result, as it appears, against the oldest note
	always @(posedge ref_clk)
	begin
		aborts += int'(receive_transfer_abort === 1'b1);
		if (got_valid)
			check({1'b0, got}, exp_tx.size() ? exp_tx.pop_front() : 12'hFFF);
		if (load_receive_regs_strobe)
			check({frame_error_flag, rx_frame}, exp_rx.size() ? exp_rx.pop_front() : 12'hFFF);
	end
	initial
	begin
		repeat (6) @(posedge ref_clk);
		#5 nrst = 1;
		listener_active_bit = 1;
		// data and command frames are passed on, then handed to the host
		for (int k = 0; k < 5; k++)
		begin
			f = {k[0] ? lfa_pkg::CTRL_CMD : 3'(k), 1'b0, 7'($random(seed))};
			exp_tx.push_back({1'b0, f});
			exp_rx.push_back({1'b0, f});
			if (k == 4)
				far.send(f, 3); // sync after three bits, before early retransmit, abandons it
			far.send(f, 11);
			take();
		end
		// fill the queue until it refuses; echoed frames must check clean
		listener_active_bit = 0;
		echo = 1;
		for (n = 0; out_write_ready === 1'b1 && n < 20; n++)
		begin
			out_write_data = {1'b0, 10'($random(seed))};
			out_write_valid = 1;
			exp_tx.push_back({1'b0, out_write_data});
			@(posedge ref_clk);
			#5;
		end
		out_write_valid = 0;
		check(12'(n >= 16 && n < 20), 12'h001);
		for (n = 0; n < 20000 && exp_tx.size() != 0; n++)
			@(posedge ref_clk);
		repeat (600) @(posedge ref_clk);
		check(12'(exp_tx.size() + exp_rx.size()), 12'h000);
		check({11'h0, output_available_flag}, 12'h001);
		check(12'(aborts), 12'h001);
		// interface clear reaches a non-system controller; host resets and resends it
		#5 echo = 0;
		controller_active_bit = 1;
		f = {lfa_pkg::CTRL_CMD, lfa_pkg::IFC_DATA};
		far.send(f, 11);
		for (n = 0; interface_clear_received !== 1'b1 && n < 3000; n++)
			@(posedge ref_clk);
		check({11'h0, interface_clear_received}, 12'h001);
		repeat (40) @(posedge ref_clk);
		#5 {controller_active_bit, clear_interface_clear, out_write_valid} = 3'b011;
		out_write_data = f;
		exp_tx.push_back({1'b0, f});
		@(posedge ref_clk);
		#5 {clear_interface_clear, out_write_valid} = 2'b00;
		for (n = 0; n < 3000 && exp_tx.size() != 0; n++)
			@(posedge ref_clk);
		check({10'h0, output_available_flag, interface_clear_received}, 12'h000);
		check(12'(exp_tx.size()), 12'h000);
		end_of_test();
	end
endmodule
